// ### hw/acg_glue.sv
// Glue logic joining an asynchronous 16-bit processor bus to a byte-wide serial controller.
`timescale 1ns/10ps
module acg_glue
    import acg_pkg::*;
#(
    parameter int WAIT_CYCLES = STROBE_CYCLES,
    parameter int SETTLE_CLKS = CHAIN_SETTLE_CLKS,
    parameter logic [22:0] ADDR_BASE = BASE_DEFAULT,
    parameter logic [22:0] ADDR_MASK = MASK_DEFAULT,
    parameter logic [2:0] IRQ_LEVEL = 3'h5,
    parameter bit IRQ_USED = 1'b1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire acg_bus_s bus,
    input wire logic chain_enable_in,
    output acg_periph_s periph,
    output logic chain_enable_out,
    output logic [7:0] level_ack_n,
    output logic any_sel_n,
    output logic xfer_ack_n_out,
    output logic xfer_ack_n_oe_n
);
    localparam int CNT_W = $clog2(WAIT_CYCLES + SETTLE_CLKS + 2) + 1;
    localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(WAIT_CYCLES);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CLKS);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    // Decoded cycle type, qualified by the strobe so it cannot glitch.
    function automatic logic fc_match(input logic strobe_n, input logic [2:0] fc,
                                      input logic [2:0] code);
        fc_match = !strobe_n && (fc == code);
    endfunction : fc_match

    acg_state_e state;
    acg_state_e next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic rd_q;
    logic wr_q;
    logic ack_q;
    logic [7:0] level_q;

    wire strobe_on = !bus.addr_strobe_n && !bus.lds_n;
    wire is_iack = fc_match(bus.addr_strobe_n, bus.fc, FC_IRQ_ACK);
    wire addr_hit = ((bus.addr & ADDR_MASK) == (ADDR_BASE & ADDR_MASK));
    wire sel = strobe_on && !is_iack && addr_hit;
    // Serviced level sits on address lines one to three in acknowledge cycles.
    wire [2:0] lvl = bus.addr[2:0];
    wire iack_mine = IRQ_USED && is_iack && (lvl == IRQ_LEVEL);
    wire next_rd;
    wire next_wr;
    wire next_ack;
    wire [7:0] next_level;

    always_comb begin
        next_state = state;
        next_count = count;
        if (bus.addr_strobe_n) begin
            next_state = ACG_IDLE;
            next_count = '0;
        end else begin
            case (state)
                ACG_IDLE: begin
                    if (sel) begin
                        next_state = ACG_ACCESS;
                        next_count = ONE;
                    end else if (iack_mine && !bus.lds_n) begin
                        next_state = ACG_SETTLE;
                        next_count = ONE;
                    end
                end
                ACG_ACCESS: begin
                    next_count = count + ONE;
                    if (count == WAIT_LAST) next_state = ACG_DONE;
                end
                ACG_SETTLE: begin
                    next_count = count + ONE;
                    if (count == SETTLE_LAST) begin
                        next_state = ACG_ACCESS;
                        next_count = ONE;
                    end
                end
                ACG_DONE: next_count = count;
                default: begin
                    next_state = ACG_IDLE;
                    next_count = '0;
                end
            endcase
        end
    end

    // Read strobe runs through the access phase; in acknowledge cycles it starts after settling.
    assign next_rd = (next_state == ACG_ACCESS || next_state == ACG_DONE) && (bus.rw || is_iack);
    assign next_wr = (next_state == ACG_ACCESS || next_state == ACG_DONE) && !bus.rw && !is_iack;
    assign next_ack = (next_state == ACG_DONE);
    assign next_level = (is_iack && IRQ_USED) ? ~(8'h01 << lvl) : 8'hff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ACG_IDLE;
            count <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ack_q <= 1'b0;
            level_q <= 8'hff;
        end else begin
            state <= next_state;
            count <= next_count;
            rd_q <= next_rd;
            wr_q <= next_wr;
            ack_q <= next_ack;
            level_q <= next_level;
        end
    end

    // Chip select must stay steady across the strobe so it tracks the whole access.
    assign periph.cs_n = !(sel && !is_iack);
    assign periph.rd_n = !rd_q;
    assign periph.wr_n = !wr_q;
    assign periph.ctrl_data_sel = bus.addr[SELECT_BIT-1];
    assign periph.irq_ack_in_n = IRQ_USED ? !(iack_mine) : 1'b1;
    assign chain_enable_out = chain_enable_in;
    assign level_ack_n = level_q;
    assign any_sel_n = !(sel || iack_mine);
    // Open collector: only ever pull low, otherwise release the line.
    assign xfer_ack_n_out = 1'b0;
    assign xfer_ack_n_oe_n = !ack_q;

    AST_STROBE_WIDTH: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(ack_q) |-> $past(rd_q || wr_q, 2))
        else $error("Acknowledge without stretched strobe.");
    AST_ACK_RELEASE: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus.addr_strobe_n |=> !ack_q && count == '0)
        else $error("Acknowledge held after strobe release.");
    AST_ACK_OC: assert property (@(posedge ref_clk) disable iff (!resetn)
        xfer_ack_n_out == 1'b0)
        else $error("Acknowledge driven high.");
    AST_SETTLE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state == ACG_SETTLE && count == ONE) |-> !rd_q)
        else $error("Read strobe before chain settled.");
    AST_CS_DECODE: assert property (@(posedge ref_clk) disable iff (!resetn)
        !periph.cs_n |-> addr_hit && !bus.addr_strobe_n)
        else $error("Chip select without address match.");
    AST_IACK_QUAL: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus.addr_strobe_n |-> periph.irq_ack_in_n)
        else $error("Acknowledge decode without strobe.");
    AST_NO_IRQ: assert property (@(posedge ref_clk) disable iff (!resetn)
        !iack_mine |-> periph.irq_ack_in_n)
        else $error("Interrupt acknowledge input not held high.");
    AST_WAIT_COUNT: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state == ACG_ACCESS && count == WAIT_LAST && !bus.addr_strobe_n) |=> ack_q)
        else $error("Acknowledge missing after count.");

    // Strobes must not shorten while the processor still holds the cycle open.
    // A glitch here would cut the controller's minimum pulse width.
    AST_RD_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_q && !bus.addr_strobe_n |=> rd_q)
        else $error("Read strobe dropped inside a cycle.");
    AST_WR_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_q && !bus.addr_strobe_n |=> wr_q)
        else $error("Write strobe dropped inside a cycle.");
    AST_ONE_STROBE: assert property (@(posedge ref_clk) disable iff (!resetn)
        !(rd_q && wr_q))
        else $error("Read and write strobes together.");
    AST_ACK_WITH_STROBE: assert property (@(posedge ref_clk) disable iff (!resetn)
        ack_q |-> (rd_q || wr_q))
        else $error("Acknowledge without an active strobe.");

    // Acknowledge is a level that stands until the processor ends the cycle.
    AST_ACK_STAYS: assert property (@(posedge ref_clk) disable iff (!resetn)
        ack_q && !bus.addr_strobe_n |=> ack_q)
        else $error("Acknowledge dropped before strobe release.");
    AST_COUNT_RESTART: assert property (@(posedge ref_clk) disable iff (!resetn)
        $fell(bus.addr_strobe_n) |-> count == '0)
        else $error("Wait count not cleared at cycle start.");

    // Decoding is qualified by the address strobe, so idle bus noise selects nothing.
    AST_CS_QUAL: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus.addr_strobe_n |-> periph.cs_n)
        else $error("Chip select without address strobe.");
    AST_IACK_NO_CS: assert property (@(posedge ref_clk) disable iff (!resetn)
        is_iack |-> periph.cs_n)
        else $error("Chip select during interrupt acknowledge.");
    AST_IACK_IN: assert property (@(posedge ref_clk) disable iff (!resetn)
        iack_mine |-> !periph.irq_ack_in_n)
        else $error("Own level acknowledge not passed on.");

    // Level decode is one-cold and only ever names the serviced level.
    AST_LEVEL_ONE_COLD: assert property (@(posedge ref_clk) disable iff (!resetn)
        $countones(~level_q) <= 1)
        else $error("More than one level acknowledged.");
    AST_LEVEL_DECODE: assert property (@(posedge ref_clk) disable iff (!resetn)
        is_iack |=> !level_q[$past(lvl)])
        else $error("Serviced level not decoded.");
    AST_LEVEL_IDLE: assert property (@(posedge ref_clk) disable iff (!resetn)
        !is_iack |=> level_q == 8'hff)
        else $error("Level decode outside acknowledge.");

    // The vector read waits for the daisy chain; the chain length sets the settle count.
    AST_SETTLE_NO_RD: assert property (@(posedge ref_clk) disable iff (!resetn)
        state == ACG_SETTLE |-> !rd_q)
        else $error("Read strobe while chain settles.");
    AST_SETTLE_END_RD: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state == ACG_SETTLE && count == SETTLE_LAST && !bus.addr_strobe_n) |=> rd_q)
        else $error("Vector read missing after settling.");
    AST_IACK_RD_AFTER: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(rd_q) && is_iack |-> $past(state == ACG_SETTLE))
        else $error("Vector read without settling phase.");
    AST_IACK_NO_WR: assert property (@(posedge ref_clk) disable iff (!resetn)
        is_iack |-> !wr_q)
        else $error("Write strobe during interrupt acknowledge.");
endmodule : acg_glue

// ### hw/acg_pkg.sv
// Package with constants and carrier types for the processor to serial controller glue.
package acg_pkg;
    localparam int ADDR_W = 23;
    localparam int FC_W = 3;
    localparam int LVL_W = 3;
    localparam int SR_W = 8;
    // Processor function code that marks an interrupt acknowledge cycle.
    localparam logic [2:0] FC_IRQ_ACK = 3'h7;
    localparam logic [2:0] FC_USER_DATA = 3'h1;
    // Strobe width and settling figures, select bit and default address decode.
    localparam int STROBE_MIN_NS = 400;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STROBE_CYCLES = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CHAIN_SETTLE_CLKS = 5;
    localparam int SELECT_BIT = 1;
    localparam logic [22:0] BASE_DEFAULT = 23'h000000;
    localparam logic [22:0] MASK_DEFAULT = 23'h7ffff8;

    typedef enum logic [3:0] {
        ACG_IDLE = 4'h1,
        ACG_ACCESS = 4'h2,
        ACG_SETTLE = 4'h4,
        ACG_DONE = 4'h8
    } acg_state_e;

    // Processor side bus request.
    typedef struct packed {
        logic addr_strobe_n;
        logic rw;
        logic lds_n;
        logic [2:0] fc;
        logic [22:0] addr;
    } acg_bus_s;

    // Controller side strobes.
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic ctrl_data_sel;
        logic irq_ack_in_n;
    } acg_periph_s;
endpackage : acg_pkg

// ### tb/acg_cpu_model.sv
// Processor bus master model running byte cycles on the lower data strobe.
`timescale 1ns/10ps
module acg_cpu_model
    import acg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic ack_n,
    output acg_bus_s bus
);
    initial bus = '{1'b1, 1'b1, 1'b1, 3'h0, 23'h0};
    // The request is held while waiting up to 20 edges for acknowledge, so a later answer is not counted.
    task automatic run(input logic [22:0] a, input logic [2:0] f, input logic r, output int n);
        n = 0;
        @(posedge ref_clk);
        bus <= '{1'b0, r, 1'b0, f, a};
        for (int i = 1; i <= 20 && n == 0; i++) begin
            @(posedge ref_clk);
            #1;
            if (ack_n === 1'b0) n = i;
        end
    endtask : run
    // Released lines show an inverse pattern rather than stale values.
    task automatic idle();
        @(posedge ref_clk);
        bus <= '{1'b1, 1'b1, 1'b1, ~bus.fc, ~bus.addr};
    endtask : idle
endmodule : acg_cpu_model

// ### tb/tb_acg_glue.sv
// Self-checking bench for the processor to serial controller glue.
`timescale 1ns/10ps
module tb_acg_glue import acg_pkg::*;;
    typedef struct packed {
        logic [22:0] a;
        logic [2:0] f;
        logic r;
        int n;
        logic sel;
        logic rd_n;
        logic wr_n;
    } acg_row_s;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic chain_in = 1'b1;
    acg_bus_s bus;
    acg_periph_s periph;
    logic chain_out, any_sel_n, ack_out, ack_oe_n;
    logic [7:0] level_ack_n;
    wire logic ack_n = ack_oe_n ? 1'b1 : ack_out;
    int num_errors = 0;
    int total_checks = 0;
    int nn;
    // Shortened wait count: normal answer after 4 edges, interrupt acknowledge after 9.
    // The first row is the dummy control read that must precede the reset command.
    acg_row_s rows [6] = '{
        '{23'h1, 3'h1, 1'b1, 4, 1'b1, 1'b0, 1'b1},
        '{23'h1, 3'h1, 1'b0, 4, 1'b1, 1'b1, 1'b0},
        '{23'h6, 3'h5, 1'b1, 4, 1'b0, 1'b0, 1'b1},
        '{23'h5, 3'h7, 1'b1, 9, 1'b1, 1'b0, 1'b1},
        '{23'h8, 3'h1, 1'b1, 0, 1'b0, 1'b1, 1'b1},
        '{23'h3, 3'h7, 1'b1, 0, 1'b0, 1'b1, 1'b1}};
    acg_glue #(.WAIT_CYCLES(3)) u_acg_glue (.ref_clk(ref_clk), .resetn(resetn), .bus(bus),
        .chain_enable_in(chain_in), .periph(periph), .chain_enable_out(chain_out),
        .level_ack_n(level_ack_n), .any_sel_n(any_sel_n), .xfer_ack_n_out(ack_out),
        .xfer_ack_n_oe_n(ack_oe_n));
    acg_cpu_model u_cpu (.ref_clk(ref_clk), .ack_n(ack_n), .bus(bus));
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            u_cpu.run(rows[i].a, rows[i].f, rows[i].r, nn);
            chk(8'(nn), 8'(rows[i].n), "ack edges");
            chk(periph.rd_n, rows[i].rd_n, "read strobe");
            chk(periph.wr_n, rows[i].wr_n, "write strobe");
            chk(any_sel_n, rows[i].n == 0, "any select");
            if (rows[i].n != 0) chk(periph.ctrl_data_sel, rows[i].sel, "c/d select");
            if (rows[i].n != 0) chk(ack_out, 1'b0, "ack level");
            if (rows[i].n != 0 && rows[i].f != 3'h7) chk(periph.cs_n, 1'b0, "chip sel");
            if (rows[i].n != 0 && rows[i].f == 3'h7) begin
                chk(level_ack_n, 8'hdf, "level decode");
                chk(periph.irq_ack_in_n, 1'b0, "iack in");
            end
            u_cpu.idle();
            @(posedge ref_clk);
            #1;
            chk(ack_oe_n, 1'b1, "ack release");
            chk({periph.rd_n, periph.wr_n}, 2'h3, "strobe release");
            $display("test %0d done", i);
        end
        @(posedge ref_clk);
        chain_in <= 1'b0;
        #1;
        chk(chain_out, 1'b0, "chain pass");
        fork
            u_cpu.run(23'h0, 3'h1, 1'b1, nn);
        join_none
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(ack_oe_n, 1'b1, "ack in reset");
        chk(level_ack_n, 8'hff, "level in reset");
        chk({periph.rd_n, periph.wr_n}, 2'h3, "strobes in reset");
        repeat (22) @(posedge ref_clk);
        u_cpu.idle();
        resetn <= 1'b1;
        u_cpu.run(23'h1, 3'h1, 1'b1, nn);
        chk(8'(nn), 8'h4, "ack after reset");
        chk(periph.rd_n, 1'b0, "read after reset");
        u_cpu.idle();
        @(posedge ref_clk);
        #1;
        chk(ack_oe_n, 1'b1, "release after reset");
        $display("test reset done");
        end_sim();
    end
endmodule : tb_acg_glue
